/* bench/cpu_status_stack_interrupt_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
end
module cpu_status_stack_interrupt_core_test;
    import ccore_pkg::*;
    typedef struct {int sel; logic [15:0] val;} ccore_tb_note_s;
    localparam logic [15:0] BOOT_BASE = 16'h0C00;
    ccore_tb_note_s notes[$];
    ccore_tb_note_s nt;
    int n_fail = 0;
    int n_checks = 0;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] io_wdata, io_rdata, status_register, rd_a_data, rd_b_data;
    logic [7:0] ds_wdata, ds_rdata, irq_flag_set, irq_flag_clr, d;
    logic [7:0] irq_level_pin, irq_enable, irq_flags;
    logic [15:0] rd_word, wr_data, ds_addr, ptr_addr, stack_pointer, spe;
    logic [15:0] irq_vector, reset_vector;
    logic [4:0] rd_a_addr, rd_b_addr, wr_addr, sflags;
    logic [5:0] io_addr, ptr_disp;
    logic [3:0] f, r;
    logic [1:0] ptr_sel;
    logic io_wr, alu_flag_we, alu_n, alu_v, alu_z, alu_c, wr_en, wr_wide;
    logic ds_wr, ds_hit, ptr_go, instr_done, op_sei, op_cli, op_interrupt_return_op;
    logic vector_select_bit, boot_reset_fuse, irq_busy, irq_take;
    ccore_ptr_mode_e ptr_mode;
    ccore_sp_op_e sp_op;
    ccore_sp_op_e ops[4] = '{SP_PUSH1, SP_PUSH2, SP_POP1, SP_POP2};
    logic [15:0] dl[4] = '{16'hFFFF, 16'hFFFE, 16'h0001, 16'h0002};

    ccore_top #(.BOOT_START(BOOT_BASE)) dut (
        .ref_clk, .resetn, .io_addr, .io_wr, .io_wdata, .io_rdata,
        .alu_flag_we, .alu_n, .alu_v, .alu_z, .alu_c, .status_register,
        .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .rd_word,
        .wr_en, .wr_wide, .wr_addr, .wr_data, .ds_addr, .ds_wr, .ds_wdata,
        .ds_hit, .ds_rdata, .ptr_go, .ptr_sel, .ptr_mode, .ptr_disp,
        .ptr_addr, .sp_op, .stack_pointer, .instr_done, .op_sei, .op_cli,
        .op_interrupt_return_op, .irq_flag_set, .irq_flag_clr, .irq_level_pin, .irq_enable,
        .vector_select_bit, .boot_reset_fuse, .irq_flags, .irq_busy,
        .irq_take, .irq_vector, .reset_vector
    );

    // 20 mhz core clock
    always #25 ref_clk = ~ref_clk;

    // output picked by a note, widened so one compare fits all
    function automatic logic [15:0] got(input int sel);
        case (sel)
            0: got = {8'h00, status_register};
            1: got = stack_pointer;
            2: got = {8'h00, rd_a_data};
            3: got = {8'h00, rd_b_data};
            4: got = rd_word;
            5: got = {8'h00, ds_rdata};
            6: got = ptr_addr;
            7: got = {8'h00, irq_flags};
            8: got = irq_vector;
            9: got = {8'h00, io_rdata};
            10: got = {15'h0000, irq_busy};
            11: got = {15'h0000, irq_take};
            12: got = reset_vector;
            default: got = {15'h0000, ds_hit};
        endcase
    endfunction

    task automatic note(input int sel, input logic [15:0] val);
        notes.push_back('{sel, val});
    endtask

    // watcher: compares at the falling edge, once all has settled
    always @(negedge ref_clk) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            `CHK(got(nt.sel), nt.val)
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one instruction boundary; a return also pops the return address
    task automatic step(input logic s, input logic c, input logic rt);
        @(posedge ref_clk);
        instr_done <= 1'b1;
        {op_sei, op_cli, op_interrupt_return_op} <= {s, c, rt};
        sp_op <= rt ? SP_POP2 : SP_NONE;
        @(posedge ref_clk);
        instr_done <= 1'b0;
        {op_sei, op_cli, op_interrupt_return_op} <= 3'h0;
        sp_op <= SP_NONE;
    endtask

    task automatic io_write(input logic [5:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= v;
        @(posedge ref_clk);
        io_wr <= 1'b0;
    endtask

    task automatic done_msg(input string s);
        $display("test %s finished", s);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 120 cycles
    initial begin
        tick(4000);
        n_fail++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end

    // main sequence
    initial begin
        {io_wr, alu_flag_we, alu_n, alu_v, alu_z, alu_c, wr_en} = '0;
        {wr_wide, ds_wr, ptr_go, instr_done, op_sei, op_cli, op_interrupt_return_op} = '0;
        {vector_select_bit, boot_reset_fuse, io_addr, ptr_disp} = '0;
        {ptr_sel, rd_a_addr, rd_b_addr, wr_addr, io_wdata, ds_wdata} = '0;
        {irq_flag_set, irq_flag_clr, irq_level_pin, irq_enable} = '0;
        {wr_data, ds_addr} = '0;
        ptr_mode = PTR_PLAIN;
        sp_op = SP_NONE;
        void'($urandom(32'h149AAD1B));
        r = 4'($urandom);
        tick(4);
        resetn <= 1'b1;
        @(posedge ref_clk);
        io_addr <= STACK_POINTER_HIGH_BYTE_OFS;
        note(1, TOP_OF_DATA_MEMORY);
        note(12, RESET_VECTOR_APP);
        @(posedge ref_clk);
        io_addr <= STACK_POINTER_LOW_BYTE_OFS;
        note(9, {8'h00, TOP_OF_DATA_MEMORY[15:8]});
        @(posedge ref_clk);
        note(9, {8'h00, TOP_OF_DATA_MEMORY[7:0]});
        done_msg("reset");
        // every flag combination, offset by a random pattern
        for (int i = 0; i < 16; i++) begin
            f = 4'(i) ^ r;
            @(posedge ref_clk);
            alu_flag_we <= 1'b1;
            {alu_n, alu_v, alu_z, alu_c} <= f;
            @(posedge ref_clk);
            alu_flag_we <= 1'b0;
            sflags = {f[3] ^ f[2], f[2], f[3], f[1], f[0]};
            note(0, {11'h000, sflags});
        end
        done_msg("flags");
        @(posedge ref_clk);
        {wr_en, wr_wide, wr_addr, wr_data} <= {2'h3, PTR_X_LO, 16'h1234};
        @(posedge ref_clk);
        d = 8'($urandom);
        {wr_wide, wr_addr, wr_data} <= {1'b0, 5'h05, 8'hA5, d};
        rd_a_addr <= PTR_X_LO;
        rd_b_addr <= PTR_X_LO + 5'h01;
        note(2, 16'h0034);
        note(3, 16'h0012);
        note(4, 16'h1234);
        @(posedge ref_clk);
        {wr_en, ds_wr, ds_addr, ds_wdata} <= {2'h1, 16'h0007, ~d};
        rd_a_addr <= 5'h05;
        note(2, {8'h00, d});
        @(posedge ref_clk);
        {ds_addr, ds_wdata, rd_b_addr} <= {WREG_SPACE, d, 5'h07};
        note(3, {8'h00, ~d});
        note(13, 16'h0000);
        note(5, 16'h0000);
        @(posedge ref_clk);
        {ds_wr, ds_addr} <= {1'b0, 16'h0007};
        note(5, {8'h00, ~d});
        note(13, 16'h0001);
        done_msg("registers");
        // postincrement, predecrement, displacement on the x pair
        @(posedge ref_clk);
        {ptr_go, ptr_sel, rd_a_addr} <= {3'h4, PTR_X_LO};
        ptr_mode <= PTR_POSTINC;
        note(6, 16'h1234);
        @(posedge ref_clk);
        ptr_mode <= PTR_PREDEC;
        note(4, 16'h1235);
        note(6, 16'h1234);
        @(posedge ref_clk);
        {ptr_go, ptr_disp} <= {1'b0, 6'h3F};
        ptr_mode <= PTR_DISP;
        note(4, 16'h1234);
        note(6, 16'h1273);
        done_msg("pointer");
        // stack placed above the reserved area before any call
        io_write(STACK_POINTER_HIGH_BYTE_OFS, 8'h04);
        io_write(STACK_POINTER_LOW_BYTE_OFS, 8'h00);
        spe = 16'h0400;
        note(1, spe);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            sp_op <= ops[k];
            @(posedge ref_clk);
            sp_op <= SP_NONE;
            spe = spe + dl[k];
            note(1, spe);
        end
        done_msg("stack");
        // two flags pending, the lower vector must win
        @(posedge ref_clk);
        {irq_enable, irq_flag_set} <= {8'h0C, 8'h0C};
        @(posedge ref_clk);
        irq_flag_set <= 8'h00;
        note(7, 16'h000C);
        step(1'b0, 1'b0, 1'b0);
        note(10, 16'h0000);
        step(1'b1, 1'b0, 1'b0);
        note(10, 16'h0000);
        step(1'b0, 1'b0, 1'b0);
        note(10, 16'h0001);
        note(7, 16'h0008);
        note(8, 16'h0003);
        note(0, {11'h000, sflags});
        note(1, 16'h03FE);
        tick(2);
        note(11, 16'h0000);
        tick(1);
        note(11, 16'h0001);
        tick(1);
        note(10, 16'h0000);
        step(1'b0, 1'b0, 1'b1);
        note(1, 16'h0400);
        note(10, 16'h0000);
        tick(1);
        note(0, {8'h00, 3'h4, sflags});
        step(1'b0, 1'b0, 1'b0);
        note(10, 16'h0001);
        note(8, 16'h0004);
        tick(4);
        note(10, 16'h0000);
        done_msg("interrupt");
        // disable at the very boundary where a request is ready
        @(posedge ref_clk);
        irq_flag_set <= 8'h04;
        @(posedge ref_clk);
        irq_flag_set <= 8'h00;
        step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        note(10, 16'h0000);
        tick(1);
        note(0, {11'h000, sflags});
        note(7, 16'h0004);
        step(1'b0, 1'b0, 1'b0);
        note(10, 16'h0000);
        @(posedge ref_clk);
        irq_flag_clr <= 8'h04;
        @(posedge ref_clk);
        irq_flag_clr <= 8'h00;
        note(7, 16'h0000);
        done_msg("disable");
        // level source that vanishes, then one that stays; vectors moved
        @(posedge ref_clk);
        {irq_level_pin, irq_flag_set} <= {8'h01, 8'h02};
        {vector_select_bit, boot_reset_fuse} <= 2'h3;
        @(posedge ref_clk);
        irq_flag_set <= 8'h00;
        note(12, BOOT_BASE);
        tick(4);
        irq_level_pin <= 8'h00;
        tick(4);
        irq_enable <= 8'h0D;
        step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        note(10, 16'h0000);
        note(7, 16'h0002);
        irq_level_pin <= 8'h01;
        tick(4);
        step(1'b0, 1'b0, 1'b0);
        note(10, 16'h0001);
        note(8, BOOT_BASE + 16'h0001);
        irq_level_pin <= 8'h00;
        tick(4);
        note(10, 16'h0000);
        done_msg("level");
        wait (notes.size() == 0);
        tally_and_finish();
    end
endmodule // cpu_status_stack_interrupt_core_test
`default_nettype wire

/* hw/ccore_pkg.sv */
package ccore_pkg;
    // i/o space offsets of the core registers
    localparam logic [5:0] STATUS_REGISTER_OFS = 6'h3F;
    localparam logic [5:0] STACK_POINTER_HIGH_BYTE_OFS = 6'h3E;
    localparam logic [5:0] STACK_POINTER_LOW_BYTE_OFS = 6'h3D;
    // status register bit positions
    localparam int GIE_BIT = 7;
    localparam int T_BIT = 6;
    localparam int H_BIT = 5;
    localparam int S_BIT = 4;
    localparam int V_BIT = 3;
    localparam int N_BIT = 2;
    localparam int Z_BIT = 1;
    localparam int C_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // working register file geometry and pointer pairs
    localparam int NUM_WREGS = 32;
    localparam logic [15:0] WREG_SPACE = 16'h0020;
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    // default top of data memory, stack pointer value after reset
    localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h04FF;
    // cycles of interrupt entry, program counter pushed meanwhile
    localparam int ENTRY_CYCLES = 4;
    localparam logic [2:0] ENTRY_LAST = 3'h3;
    localparam logic [15:0] RESET_VECTOR_APP = 16'h0000;
    typedef enum logic [2:0] {
        SP_NONE, SP_PUSH1, SP_POP1, SP_PUSH2, SP_POP2
    } ccore_sp_op_e;
    typedef enum logic [1:0] {
        PTR_PLAIN, PTR_POSTINC, PTR_PREDEC, PTR_DISP
    } ccore_ptr_mode_e;
    typedef enum logic {
        ST_RUN, ST_ENTRY
    } ccore_state_e;
endpackage

/* hw/ccore_prio.sv */
`timescale 1ns/1ps
`default_nettype none
// fixed priority: lowest index, i.e. lowest vector address, wins
module ccore_prio #(
    parameter int N = 8
) (
    input wire logic [N-1:0] req, // enabled requests
    output logic valid, // any request present
    output logic [$clog2(N)-1:0] idx // winning index
);
    // scan from the top so the lowest index is the last to overwrite
    always_comb begin
        valid = |req;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = i[$clog2(N)-1:0]; // [RULE_26]
            end
        end
    end
endmodule // ccore_prio
`default_nettype wire

/* hw/ccore_top.sv */
// Behaviour
// RULE_01: sign bit 4 equals negative xor overflow
// RULE_02: bit 3 holds two's complement overflow
// RULE_03: bits 2,1,0 hold negative, zero, carry
// RULE_04: register file offers 8/16-bit read/write mixes
// RULE_05: registers mapped at lowest 32 data addresses
// RULE_06: top six registers form three pointers
// RULE_07: stack grows downward, pointer marks top
// RULE_08: push lowers by one, call/entry by two
// RULE_09: pop raises by one, returns by two
// RULE_10: pointer bytes at i/o, reset to top
// RULE_11: software sets pointer above 0x0100 first
// RULE_12: core runs on undivided clock, pipelined fetch
// RULE_13: two reads, operate, write back per cycle
// RULE_14: service needs own and global enable
// RULE_15: lower vector address means higher priority
// RULE_16: select bit and fuse move vectors to boot
// RULE_17: entry clears global enable, return sets it
// RULE_18: flags cleared on vectoring or by one-write
// RULE_19: level sources request only while present
// RULE_20: one instruction runs after interrupt return
// RULE_21: status register never saved or restored
// RULE_22: disable instruction blocks same-cycle interrupts
// RULE_23: global enable at bit 7 gates all
// RULE_24: entry lasts four cycles, instructions finish first
// RULE_25: instruction after enable runs before service
// RULE_26: lowest pending vector chosen first
`timescale 1ns/1ps
`default_nettype none
module ccore_top #(
    parameter int N_IRQ = 8,
    parameter logic [N_IRQ-1:0] LEVEL_MASK = 8'h01,
    parameter logic [15:0] TOP_OF_DATA_MEM = ccore_pkg::TOP_OF_DATA_MEMORY,
    parameter logic [15:0] BOOT_START = 16'h0C00,
    parameter logic [15:0] VEC_WORDS = 16'h0001
) (
    input wire logic ref_clk, // core clock, undivided
    input wire logic resetn, // async reset, active low
    input wire logic [5:0] io_addr, // i/o register offset
    input wire logic io_wr, // i/o write strobe
    input wire logic [7:0] io_wdata, // i/o write data
    output logic [7:0] io_rdata, // i/o read data, next cycle
    input wire logic alu_flag_we, // alu result flags valid
    input wire logic alu_n, // result negative
    input wire logic alu_v, // two's complement overflow
    input wire logic alu_z, // result zero
    input wire logic alu_c, // carry out
    output logic [7:0] status_register, // live status
    input wire logic [4:0] rd_a_addr, // operand a index
    input wire logic [4:0] rd_b_addr, // operand b index
    output logic [7:0] rd_a_data, // operand a
    output logic [7:0] rd_b_data, // operand b
    output logic [15:0] rd_word, // pair at rd_a_addr, even
    input wire logic wr_en, // result write
    input wire logic wr_wide, // 16-bit result
    input wire logic [4:0] wr_addr, // result index
    input wire logic [15:0] wr_data, // result, low byte only unless wide
    input wire logic [15:0] ds_addr, // data-space address
    input wire logic ds_wr, // data-space write
    input wire logic [7:0] ds_wdata, // data-space write data
    output logic ds_hit, // address inside register file
    output logic [7:0] ds_rdata, // register read by address
    input wire logic ptr_go, // pointer access this cycle
    input wire logic [1:0] ptr_sel, // 0 x, 1 y, 2 z
    input wire ccore_pkg::ccore_ptr_mode_e ptr_mode, // mode
    input wire logic [5:0] ptr_disp, // displacement
    output logic [15:0] ptr_addr, // effective address
    input wire ccore_pkg::ccore_sp_op_e sp_op, // stack op
    output logic [15:0] stack_pointer, // current top of stack
    input wire logic instr_done, // instruction completes
    input wire logic op_sei, // enable instruction done
    input wire logic op_cli, // disable instruction done
    input wire logic op_interrupt_return_op, // interrupt return done
    input wire logic [N_IRQ-1:0] irq_flag_set, // flag events
    input wire logic [N_IRQ-1:0] irq_flag_clr, // write-one clear
    input wire logic [N_IRQ-1:0] irq_level_pin, // level pins
    input wire logic [N_IRQ-1:0] irq_enable, // own enables
    input wire logic vector_select_bit, // vectors to boot
    input wire logic boot_reset_fuse, // reset vector to boot
    output logic [N_IRQ-1:0] irq_flags, // pending flags
    output logic irq_busy, // entry sequence running
    output logic irq_take, // pulse, vector valid
    output logic [15:0] irq_vector, // handler address
    output logic [15:0] reset_vector // reset address
);
    import ccore_pkg::*;

    localparam int IW = $clog2(N_IRQ);

    // one-hot style match used for every write port
    function automatic logic hit5(input logic [4:0] a, input int i);
        hit5 = (a == i[4:0]);
    endfunction

    logic [7:0] wreg_reg [NUM_WREGS];
    logic [7:0] wreg_next [NUM_WREGS];
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [15:0] sp_reg;
    logic [15:0] sp_next;
    logic [7:0] io_rdata_reg;
    logic [7:0] io_rdata_next;
    logic [N_IRQ-1:0] flag_reg;
    logic [N_IRQ-1:0] flag_next;
    logic [N_IRQ-1:0] lvl_meta_reg;
    logic [N_IRQ-1:0] lvl_sync_reg;
    ccore_state_e st_reg;
    ccore_state_e st_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [15:0] vec_reg;
    logic [15:0] vec_next;
    logic [IW-1:0] pick_idx;
    logic pick_valid;
    logic [N_IRQ-1:0] req;
    logic accept;
    logic [N_IRQ-1:0] take_mask;
    logic io_stat_wr;
    logic io_sph_wr;
    logic io_spl_wr;
    logic [4:0] ptr_lo;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic ptr_upd;
    logic [15:0] vec_base;

    // i/o decode
    assign io_stat_wr = io_wr && (io_addr == STATUS_REGISTER_OFS);
    assign io_sph_wr = io_wr && (io_addr == STACK_POINTER_HIGH_BYTE_OFS);
    assign io_spl_wr = io_wr && (io_addr == STACK_POINTER_LOW_BYTE_OFS);

    // sign is derived, never stored, so it cannot drift from n and v
    assign status_register = {stat_reg[7:5],
        stat_reg[N_BIT] ^ stat_reg[V_BIT], stat_reg[3:0]}; // [RULE_01]

    // status update; interrupt entry only touches the enable bit,
    // the flags are left for the handler to save itself [RULE_21]
    always_comb begin
        stat_next = stat_reg;
        if (io_stat_wr) begin
            stat_next = io_wdata;
        end
        if (alu_flag_we) begin
            stat_next[V_BIT] = alu_v; // [RULE_02]
            stat_next[N_BIT] = alu_n; // [RULE_03]
            stat_next[Z_BIT] = alu_z; // [RULE_03]
            stat_next[C_BIT] = alu_c; // [RULE_03]
        end
        if (op_sei || op_interrupt_return_op) begin
            stat_next[GIE_BIT] = 1'b1; // [RULE_17]
        end
        if (op_cli || accept) begin
            stat_next[GIE_BIT] = 1'b0; // [RULE_17] [RULE_22]
        end
        stat_next[S_BIT] = 1'b0;
    end

    // register file reads, single cycle [RULE_04] [RULE_13]
    assign rd_a_data = wreg_reg[rd_a_addr];
    assign rd_b_data = wreg_reg[rd_b_addr];
    assign rd_word = {wreg_reg[{rd_a_addr[4:1], 1'b1}],
        wreg_reg[{rd_a_addr[4:1], 1'b0}]}; // [RULE_04]

    // registers also answer the lowest data addresses [RULE_05]
    assign ds_hit = (ds_addr < WREG_SPACE);
    assign ds_rdata = ds_hit ? wreg_reg[ds_addr[4:0]] : 8'h00;

    // pointer pairs from the top six registers [RULE_06]
    assign ptr_lo = (ptr_sel == 2'h0) ? PTR_X_LO :
        (ptr_sel == 2'h1) ? PTR_Y_LO : PTR_Z_LO;
    assign ptr_val = {wreg_reg[ptr_lo + 5'h01], wreg_reg[ptr_lo]};
    assign ptr_addr = (ptr_mode == PTR_PREDEC) ? ptr_val - 16'h0001 :
        (ptr_mode == PTR_DISP) ? ptr_val + {10'h000, ptr_disp} :
        ptr_val; // [RULE_06]
    assign ptr_new = (ptr_mode == PTR_POSTINC) ? ptr_val + 16'h0001 :
        ptr_val - 16'h0001;
    assign ptr_upd = ptr_go &&
        (ptr_mode == PTR_POSTINC || ptr_mode == PTR_PREDEC);

    // per register write arbitration: result port beats data space
    // beats pointer update, the last being the least likely clash
    generate
        for (genvar i = 0; i < NUM_WREGS; i++) begin : g_wreg
            always_comb begin
                wreg_next[i] = wreg_reg[i];
                if (ptr_upd && hit5({ptr_lo[4:1], 1'b0}, i & 30)) begin
                    wreg_next[i] = (i % 2 == 1) ? ptr_new[15:8] :
                        ptr_new[7:0]; // [RULE_06]
                end
                if (ds_wr && ds_hit && hit5(ds_addr[4:0], i)) begin
                    wreg_next[i] = ds_wdata; // [RULE_05]
                end
                if (wr_en && !wr_wide && hit5(wr_addr, i)) begin
                    wreg_next[i] = wr_data[7:0]; // [RULE_04]
                end
                if (wr_en && wr_wide && hit5({wr_addr[4:1], 1'b0}, i & 30))
                begin
                    wreg_next[i] = (i % 2 == 1) ? wr_data[15:8] :
                        wr_data[7:0]; // [RULE_04]
                end
            end
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    wreg_reg[i] <= 8'h00;
                end else begin
                    wreg_reg[i] <= wreg_next[i]; // [RULE_13]
                end
            end
        end
    endgenerate

    // stack pointer: entry beats i/o writes beats ordinary ops;
    // a pointer left below 0x0100 is software's mistake [RULE_11]
    always_comb begin
        sp_next = sp_reg;
        if (accept) begin
            sp_next = sp_reg - 16'h0002; // [RULE_08] [RULE_24]
        end else if (io_sph_wr) begin
            sp_next = {io_wdata, sp_reg[7:0]}; // [RULE_10]
        end else if (io_spl_wr) begin
            sp_next = {sp_reg[15:8], io_wdata}; // [RULE_10]
        end else begin
            case (sp_op)
                SP_PUSH1: sp_next = sp_reg - 16'h0001; // [RULE_07]
                SP_PUSH2: sp_next = sp_reg - 16'h0002; // [RULE_08]
                SP_POP1: sp_next = sp_reg + 16'h0001; // [RULE_09]
                SP_POP2: sp_next = sp_reg + 16'h0002; // [RULE_09]
                default: sp_next = sp_reg;
            endcase
        end
    end
    assign stack_pointer = sp_reg;

    // registered i/o read, unmapped offsets read zero
    assign io_rdata_next =
        (io_addr == STATUS_REGISTER_OFS) ? status_register :
        (io_addr == STACK_POINTER_HIGH_BYTE_OFS) ? sp_reg[15:8] :
        (io_addr == STACK_POINTER_LOW_BYTE_OFS) ? sp_reg[7:0] : 8'h00;
    assign io_rdata = io_rdata_reg;

    // level pins cross in through two flops before any use
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lvl_meta_reg <= '0;
            lvl_sync_reg <= '0;
        end else begin
            lvl_meta_reg <= irq_level_pin;
            lvl_sync_reg <= lvl_meta_reg;
        end
    end

    // requests: flags stick, levels only while present
    assign req = ((LEVEL_MASK & lvl_sync_reg) | (~LEVEL_MASK & flag_reg))
        & irq_enable; // [RULE_14] [RULE_19]

    ccore_prio #(.N(N_IRQ)) u_prio (
        .req(req),
        .valid(pick_valid),
        .idx(pick_idx)
    ); // [RULE_15] [RULE_26]

    // accept only at an instruction boundary, so multi-cycle ones
    // finish first; the boundary of sei, cli or interrupt_return_op never accepts
    assign accept = (st_reg == ST_RUN) && instr_done && pick_valid &&
        stat_reg[GIE_BIT] && !op_cli && !op_sei && !op_interrupt_return_op;
    // [RULE_14] [RULE_20] [RULE_22] [RULE_23] [RULE_24] [RULE_25]

    assign take_mask = accept ?
        (~LEVEL_MASK & (N_IRQ'(1) << pick_idx)) : '0;

    // an event in the clearing cycle wins so it is never lost
    assign flag_next = (flag_reg & ~irq_flag_clr & ~take_mask)
        | (irq_flag_set & ~LEVEL_MASK); // [RULE_18]
    assign irq_flags = flag_reg;

    // vectors sit low in program space, optionally in boot space
    assign vec_base = vector_select_bit ? BOOT_START : 16'h0000;
    assign vec_next = accept ? 16'(vec_base +
        (16'(pick_idx) + 16'h0001) * VEC_WORDS) : vec_reg; // [RULE_16]
    assign reset_vector = boot_reset_fuse ? BOOT_START :
        RESET_VECTOR_APP; // [RULE_16]

    // entry sequence timing
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            ST_RUN: begin
                if (accept) begin
                    st_next = ST_ENTRY;
                    cnt_next = 3'h0;
                end
            end
            ST_ENTRY: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == ENTRY_LAST) begin
                    st_next = ST_RUN; // [RULE_24]
                end
            end
            default: st_next = ST_RUN;
        endcase
    end
    assign irq_busy = (st_reg == ST_ENTRY);
    assign irq_take = (st_reg == ST_ENTRY) && (cnt_reg == ENTRY_LAST);
    assign irq_vector = vec_reg;

    // all core state on the undivided clock [RULE_12]
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stat_reg <= STATUS_RESET;
            sp_reg <= TOP_OF_DATA_MEM; // [RULE_10]
            io_rdata_reg <= 8'h00;
            flag_reg <= '0;
            st_reg <= ST_RUN;
            cnt_reg <= 3'h0;
            vec_reg <= 16'h0000;
        end else begin
            stat_reg <= stat_next;
            sp_reg <= sp_next;
            io_rdata_reg <= io_rdata_next;
            flag_reg <= flag_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            vec_reg <= vec_next;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic [IW-1:0] last_idx_reg;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            last_idx_reg <= '0;
        end else if (accept) begin
            last_idx_reg <= pick_idx;
        end
    end

    sequence s_accept;
        accept;
    endsequence
    sequence s_entry_done;
        irq_busy [*3] ##1 (irq_busy && irq_take);
    endsequence

    property p_sign;
        status_register[S_BIT] == (status_register[N_BIT]
            ^ status_register[V_BIT]);
    endproperty
    a_sign: assert property (p_sign) // [RULE_01]
        else $error("sign bit differs from n xor v");

    property p_flags;
        alu_flag_we |=> stat_reg[3:0] ==
            {$past(alu_v), $past(alu_n), $past(alu_z), $past(alu_c)};
    endproperty
    a_flags: assert property (p_flags) // [RULE_03]
        else $error("alu flags not captured");

    property p_entry;
        s_accept |=> s_entry_done ##1 !irq_busy;
    endproperty
    a_entry: assert property (p_entry) // [RULE_24]
        else $error("entry not four cycles");

    property p_entry_state;
        s_accept |=> !stat_reg[GIE_BIT] && sp_reg == $past(sp_reg) - 2
            && (!flag_reg[last_idx_reg] || LEVEL_MASK[last_idx_reg]);
    endproperty
    a_entry_state: assert property (p_entry_state) // [RULE_17]
        else $error("entry did not clear enable, flag or push");

    property p_block;
        (op_cli || op_sei || op_interrupt_return_op || !stat_reg[GIE_BIT]) |-> !accept;
    endproperty
    a_block: assert property (p_block) // [RULE_22]
        else $error("interrupt taken while blocked");

    property p_interrupt_return_op;
        op_interrupt_return_op && sp_op == SP_POP2 && !io_wr |=>
            stat_reg[GIE_BIT] && sp_reg == $past(sp_reg) + 2;
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op) // [RULE_09]
        else $error("return did not restore enable and pointer");

    property p_push1;
        sp_op == SP_PUSH1 && !accept && !io_wr |=>
            sp_reg == $past(sp_reg) - 1;
    endproperty
    a_push1: assert property (p_push1) // [RULE_07]
        else $error("push did not lower pointer by one");

    property p_pop1;
        sp_op == SP_POP1 && !accept && !io_wr |=>
            sp_reg == $past(sp_reg) + 1;
    endproperty
    a_pop1: assert property (p_pop1) // [RULE_09]
        else $error("pop did not raise pointer by one");

    property p_pending;
        irq_flag_set[2] && !LEVEL_MASK[2] |=> flag_reg[2];
    endproperty
    a_pending: assert property (p_pending) // [RULE_18]
        else $error("flag event lost");

    property p_prio;
        accept && req[0] |-> pick_idx == '0;
    endproperty
    a_prio: assert property (p_prio) // [RULE_26]
        else $error("lowest vector not chosen");
endmodule // ccore_top
`default_nettype wire
